// >>> include/ssr_pkg.sv
// shared constants and carriers for the status and sample-count register group
package ssr_pkg;
    // register offsets
    localparam logic [7:0] ADDR_SYNC_LOCK_STATUS = 8'h2D;
    localparam logic [7:0] ADDR_OUTPUT_READY_STATUS = 8'h2E;
    localparam logic [7:0] ADDR_EVENT_FLAG_STATUS = 8'h2F;
    localparam logic [7:0] ADDR_SAMPLE_COUNT_LOW = 8'h30;
    localparam logic [7:0] ADDR_SAMPLE_COUNT_MID = 8'h31;
    localparam logic [7:0] ADDR_SAMPLE_COUNT_HIGH = 8'h32;
    // sync_lock_status fields
    localparam int CMD_DONE_BIT = 7;
    localparam int LOCKED_BIT = 1;
    localparam int AVAIL_BIT = 0;
    // output_ready_status fields
    localparam int FUSION_NEW_BIT = 3;
    localparam int RATE_NEW_BIT = 1;
    localparam int ACCEL_NEW_BIT = 0;
    // event_flag_status fields
    localparam int SIG_MOTION_BIT = 7;
    localparam int NO_MOTION_BIT = 6;
    localparam int ANY_MOTION_BIT = 5;
    localparam int STEP_BIT = 4;
    localparam int TAP_BIT = 1;
    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [23:0] COUNT_RESET = 24'h000000;
    localparam logic [23:0] COUNT_STEP = 24'h000001;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // one event per producer, one-cycle pulses
    typedef struct packed {
        logic fusion_new;
        logic rate_new;
        logic accel_new;
    } ssr_data_evt_s;

    typedef struct packed {
        logic sig_motion;
        logic no_motion;
        logic any_motion;
        logic step;
        logic tap;
    } ssr_motion_evt_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ssr_bus_req_s;
endpackage

// >>> verilog/ssr_sync3.sv
// three-stage synchroniser for pin-level inputs, change taken when stages two and three agree
`timescale 1ns/1ps
module ssr_sync3 (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // data
    input wire logic async_in,
    output logic sync_out
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic out_reg;
    logic out_next;

    always_comb begin
        stage_next = {stage_reg[1:0], async_in};
        out_next = out_reg;
        if (stage_reg[1] == stage_reg[2]) begin
            out_next = stage_reg[2];
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage_reg <= 3'h0;
            out_reg <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule

// >>> verilog/ssr_sticky.sv
// sticky new-data flag, set by an event pulse, cleared by a host read; set wins
`timescale 1ns/1ps
module ssr_sticky (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // control
    input wire logic set_in,
    input wire logic clear_in,
    output logic flag_out
);
    logic flag_reg;
    logic flag_next;

    always_comb begin
        flag_next = flag_reg;
        if (clear_in) begin
            flag_next = 1'b0;
        end
        // an event in the clearing cycle stays visible
        if (set_in) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_out = flag_reg;
endmodule

// >>> verilog/ssr_status_regs.sv
// status, event and sample-count register group with a plain register port
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

module ssr_status_regs (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // configuration and command engine, same clock
    input wire logic sync_sample_enable_in,
    input wire logic command_done_in,
    input wire logic command_start_in,
    input wire logic data_locked_in,
    input wire logic data_avail_in,
    // interrupt pins as driven by the device, asynchronous
    input wire logic interrupt_pin_one_in,
    input wire logic interrupt_pin_two_in,
    // producers, one-cycle pulses
    input wire ssr_pkg::ssr_data_evt_s data_evt_in,
    input wire ssr_pkg::ssr_motion_evt_s motion_evt_in,
    input wire logic sample_set_done_in,
    // observation
    output logic [23:0] sample_counter_out
);
    ssr_pkg::ssr_bus_req_s req;
    logic int_one_sync;
    logic int_two_sync;
    logic fusion_flag;
    logic rate_flag;
    logic accel_flag;
    logic rd_ready;
    logic rd_event;
    logic [4:0] motion_flag;

    logic cmd_done_reg;
    logic cmd_done_next;
    logic [23:0] count_reg;
    logic [23:0] count_next;
    logic [23:0] snap_reg;
    logic [23:0] snap_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // writes are accepted on the port and discarded: every location is read-only
    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

    function automatic logic hit(input ssr_pkg::ssr_bus_req_s r, input logic [7:0] a);
        hit = r.rd && (r.addr == a);
    endfunction

    assign rd_ready = hit(req, ssr_pkg::ADDR_OUTPUT_READY_STATUS);
    assign rd_event = hit(req, ssr_pkg::ADDR_EVENT_FLAG_STATUS);

    ssr_sync3 u_sync_one (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .async_in(interrupt_pin_one_in),
        .sync_out(int_one_sync)
    );

    ssr_sync3 u_sync_two (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .async_in(interrupt_pin_two_in),
        .sync_out(int_two_sync)
    );

    ssr_sticky u_fusion (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .set_in(data_evt_in.fusion_new),
        .clear_in(rd_ready),
        .flag_out(fusion_flag)
    );

    ssr_sticky u_rate (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .set_in(data_evt_in.rate_new),
        .clear_in(rd_ready),
        .flag_out(rate_flag)
    );

    ssr_sticky u_accel (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .set_in(data_evt_in.accel_new),
        .clear_in(rd_ready),
        .flag_out(accel_flag)
    );

    // motion flags are sticky too and drop when the event register is read
    for (genvar i = 0; i < 5; i++) begin : g_motion
        ssr_sticky u_motion (
            .clk_sys_in(clk_sys_in),
            .reset_n_in(reset_n_in),
            .set_in(motion_evt_in[i]),
            .clear_in(rd_event),
            .flag_out(motion_flag[i])
        );
    end

    // command-complete: cleared when a new command starts, set by completion
    always_comb begin
        cmd_done_next = cmd_done_reg;
        if (command_start_in) begin
            cmd_done_next = 1'b0;
        end
        if (command_done_in) begin
            cmd_done_next = 1'b1;
        end
    end

    // sample counter with snapshot of the upper bytes on a low-byte read
    always_comb begin
        count_next = count_reg;
        if (sample_set_done_in) begin
            count_next = count_reg + ssr_pkg::COUNT_STEP;
        end
        snap_next = snap_reg;
        if (hit(req, ssr_pkg::ADDR_SAMPLE_COUNT_LOW)) begin
            // a carry mid-burst cannot tear the value read back
            snap_next = count_reg;
        end
    end

    // read data, one cycle after the strobe
    always_comb begin
        rdata_next = ssr_pkg::READ_ZERO;
        if (req.rd) begin
            case (req.addr)
                ssr_pkg::ADDR_SYNC_LOCK_STATUS: begin
                    rdata_next[ssr_pkg::CMD_DONE_BIT] = cmd_done_reg;
                    if (sync_sample_enable_in) begin
                        rdata_next[ssr_pkg::LOCKED_BIT] = data_locked_in;
                        rdata_next[ssr_pkg::AVAIL_BIT] = data_avail_in;
                    end else begin
                        rdata_next[ssr_pkg::LOCKED_BIT] = int_one_sync;
                        rdata_next[ssr_pkg::AVAIL_BIT] = int_two_sync;
                    end
                end
                ssr_pkg::ADDR_OUTPUT_READY_STATUS: begin
                    rdata_next[ssr_pkg::FUSION_NEW_BIT] = fusion_flag;
                    rdata_next[ssr_pkg::RATE_NEW_BIT] = rate_flag;
                    rdata_next[ssr_pkg::ACCEL_NEW_BIT] = accel_flag;
                end
                ssr_pkg::ADDR_EVENT_FLAG_STATUS: begin
                    rdata_next[ssr_pkg::SIG_MOTION_BIT] = motion_flag[4];
                    rdata_next[ssr_pkg::NO_MOTION_BIT] = motion_flag[3];
                    rdata_next[ssr_pkg::ANY_MOTION_BIT] = motion_flag[2];
                    rdata_next[ssr_pkg::STEP_BIT] = motion_flag[1];
                    rdata_next[ssr_pkg::TAP_BIT] = motion_flag[0];
                end
                ssr_pkg::ADDR_SAMPLE_COUNT_LOW: begin
                    rdata_next = count_reg[7:0];
                end
                ssr_pkg::ADDR_SAMPLE_COUNT_MID: begin
                    rdata_next = snap_reg[15:8];
                end
                ssr_pkg::ADDR_SAMPLE_COUNT_HIGH: begin
                    rdata_next = snap_reg[23:16];
                end
                default: begin
                    rdata_next = ssr_pkg::READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cmd_done_reg <= 1'b0;
            count_reg <= ssr_pkg::COUNT_RESET;
            snap_reg <= ssr_pkg::COUNT_RESET;
            rdata_reg <= ssr_pkg::STATUS_RESET;
        end else begin
            cmd_done_reg <= cmd_done_next;
            count_reg <= count_next;
            snap_reg <= snap_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign sample_counter_out = count_reg;
endmodule

// >>> verification/ssr_status_regs_assertions.sv
// assertion checker for the status and sample-count register group
`timescale 1ns/1ps
module ssr_status_regs_chk (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // watched ports
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic sync_sample_enable_in,
    input wire logic data_locked_in,
    input wire logic data_avail_in,
    input wire logic sample_set_done_in,
    input wire logic [23:0] sample_counter_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    property p_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_unmapped;
        reg_rd_in && (reg_addr_in < 8'h2D || reg_addr_in > 8'h32) |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_sls_res; reg_rd_in && reg_addr_in == 8'h2D |=> reg_rdata_out[6:2] == 5'h00; endproperty
    a_sls_res: assert property (p_sls_res) else $error("lock status reserved set");
    property p_ors_res;
        reg_rd_in && reg_addr_in == 8'h2E |=> reg_rdata_out[7:4] == 4'h0 && !reg_rdata_out[2];
    endproperty
    a_ors_res: assert property (p_ors_res) else $error("ready status reserved set");
    property p_efs_res;
        reg_rd_in && reg_addr_in == 8'h2F |=> reg_rdata_out[3:2] == 2'h0 && !reg_rdata_out[0];
    endproperty
    a_efs_res: assert property (p_efs_res) else $error("event status reserved set");
    property p_sync;
        reg_rd_in && reg_addr_in == 8'h2D && sync_sample_enable_in
            |=> reg_rdata_out[1] == $past(data_locked_in)
                && reg_rdata_out[0] == $past(data_avail_in);
    endproperty
    a_sync: assert property (p_sync) else $error("lock or avail bit wrong");
    property p_low;
        reg_rd_in && reg_addr_in == 8'h30 |=> reg_rdata_out == 8'($past(sample_counter_out));
    endproperty
    a_low: assert property (p_low) else $error("low count byte wrong");
    property p_step;
        sample_set_done_in |=> sample_counter_out == $past(sample_counter_out) + 24'h000001;
    endproperty
    a_step: assert property (p_step) else $error("count did not step");
    property p_hold; !sample_set_done_in |=> $stable(sample_counter_out); endproperty
    a_hold: assert property (p_hold) else $error("count moved without sample");
endmodule

bind ssr_status_regs ssr_status_regs_chk i_chk (.clk_sys_in, .reset_n_in, .reg_addr_in,
    .reg_rd_in, .reg_rdata_out, .sync_sample_enable_in, .data_locked_in, .data_avail_in,
    .sample_set_done_in, .sample_counter_out);

// >>> verification/ssr_host_model.sv
// host model: reads and writes on the plain register port
`timescale 1ns/1ps
module ssr_host_model (
    // clock
    input wire logic clk_sys_in,
    // register port
    output logic [7:0] reg_addr_out = 8'h00,
    output logic [7:0] reg_wdata_out = 8'h00,
    output logic reg_wr_out = 1'b0,
    output logic reg_rd_out = 1'b0,
    input wire logic [7:0] reg_rdata_in
);
    // address scrambled after each wr and rd strobe so a stale value never helps
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        #1 d = reg_rdata_in;
    endtask
    task automatic rd_cnt(output logic [23:0] v);
        @(posedge clk_sys_in);
        reg_addr_out <= 8'h30;
        reg_rd_out <= 1'b1;
        for (int i = 1; i < 4; i++) begin
            @(posedge clk_sys_in);
            reg_addr_out <= 8'h30 + 8'(i);
            reg_rd_out <= (i < 3);
            #1 v[8*(i-1) +: 8] = reg_rdata_in;
        end
    endtask
endmodule

// >>> verification/tb_ssr_status_regs.sv
// testbench for the status and sample-count register group
`timescale 1ns/1ps
module tb_ssr_status_regs;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd;
    logic sync_en = 1'b0, locked = 1'b0, avail = 1'b0, pin1 = 1'b0, pin2 = 1'b0;
    logic sset = 1'b0, cmd_done = 1'b0, cmd_start = 1'b0;
    ssr_pkg::ssr_data_evt_s dev = '0;
    ssr_pkg::ssr_motion_evt_s mev = '0;
    logic [23:0] count, v;
    logic [4:0] lv[6] = '{5'h18, 5'h14, 5'h13, 5'h02, 5'h01, 5'h0C};
    logic [7:0] le[6] = '{8'h02, 8'h01, 8'h00, 8'h02, 8'h01, 8'h00};
    logic [7:0] de[3] = '{8'h08, 8'h02, 8'h01};
    logic [7:0] me[5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h02};
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    initial forever #2 clk_sys_in = ~clk_sys_in;
    ssr_status_regs i_dut (.clk_sys_in, .reset_n_in, .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .sync_sample_enable_in(sync_en),
        .command_done_in(cmd_done), .command_start_in(cmd_start), .data_locked_in(locked),
        .data_avail_in(avail), .interrupt_pin_one_in(pin1), .interrupt_pin_two_in(pin2),
        .data_evt_in(dev), .motion_evt_in(mev), .sample_set_done_in(sset),
        .sample_counter_out(count));
    ssr_host_model i_host (.clk_sys_in, .reg_addr_out(addr), .reg_wdata_out(wdata),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, d);
        chk({16'h0000, d}, {16'h0000, e});
    endtask
    task automatic ev(input logic [2:0] dv, input logic [4:0] mv, input logic s, cd, cs);
        @(posedge clk_sys_in);
        dev <= dv;
        mev <= mv;
        sset <= s;
        cmd_done <= cd;
        cmd_start <= cs;
        @(posedge clk_sys_in);
        dev <= '0;
        mev <= '0;
        sset <= 1'b0;
        cmd_done <= 1'b0;
        cmd_start <= 1'b0;
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        for (int a = 8'h2D; a < 8'h34; a++) begin
            i_host.wr(8'(a), 8'hFF);
            rc(8'(a), 8'h00);
        end
        done("reset and writes");
        ev(3'h0, 5'h00, 1'b0, 1'b1, 1'b0);
        rc(8'h2D, 8'h80);
        // completion and a new start in one cycle: completion wins
        ev(3'h0, 5'h00, 1'b0, 1'b1, 1'b1);
        rc(8'h2D, 8'h80);
        ev(3'h0, 5'h00, 1'b0, 1'b0, 1'b1);
        rc(8'h2D, 8'h00);
        done("command flag");
        // pins pass a synchroniser, so settle before reading
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys_in);
            {sync_en, locked, avail, pin1, pin2} <= lv[i];
            repeat (6) @(posedge clk_sys_in);
            rc(8'h2D, le[i]);
        end
        done("lock and avail");
        for (int i = 0; i < 3; i++) begin
            ev(3'b100 >> i, 5'h00, 1'b0, 1'b0, 1'b0);
            rc(8'h2E, de[i]);
            rc(8'h2E, 8'h00);
        end
        // new data in the clearing read's cycle must survive that read
        fork
            i_host.rd(8'h2E, d);
            ev(3'h4, 5'h00, 1'b0, 1'b0, 1'b0);
        join
        chk({16'h0000, d}, 24'h000000);
        rc(8'h2E, 8'h08);
        for (int i = 0; i < 5; i++) begin
            ev(3'h0, 5'b10000 >> i, 1'b0, 1'b0, 1'b0);
            rc(8'h2F, me[i]);
            rc(8'h2F, 8'h00);
        end
        done("new data and events");
        repeat (300) ev(3'h0, 5'h00, 1'b1, 1'b0, 1'b0);
        // let the last increment land before looking
        @(negedge clk_sys_in);
        chk(count, 24'h00012C);
        @(posedge clk_sys_in);
        sset <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        sset <= 1'b0;
        @(posedge clk_sys_in);
        chk(count, 24'h000130);
        i_host.rd_cnt(v);
        chk(v, 24'h000130);
        rc(8'h31, 8'h01);
        done("sample counter");
        finish_test();
    end
endmodule
